// File: common/oscsd_pkg.sv
// package: register map, field layout and timing constants for the oscillator select block
package oscsd_pkg;
  localparam int ADDR_W = 4;
  // byte addresses of the registers (word aligned)
  localparam logic [3:0] OFF_OSC_CONTROL = 4'h0;
  localparam logic [3:0] OFF_CLOCK_DIVIDER = 4'h4;
  localparam logic [3:0] OFF_FAST_RC_TUNE = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  // oscillator_control fields
  localparam int CUR_SEL_LSB = 12;
  localparam int NEXT_SEL_LSB = 8;
  localparam int SEL_LOCK_BIT = 7;
  localparam int PLL_LOCK_BIT = 5;
  localparam int CLK_FAIL_BIT = 3;
  localparam int SECONDARY_OSC_DRV_BIT = 2;
  localparam int SECONDARY_OSC_EN_BIT = 1;
  localparam int SWITCH_REQ_BIT = 0;
  // clock_divider fields and the fast rc tune trim field
  localparam int RECOVER_IRQ_BIT = 15;
  localparam int RATIO_LSB = 12;
  localparam int RATIO_EN_BIT = 11;
  localparam int POSTSCALE_LSB = 8;
  localparam int TRIM_LSB = 0;
  // reset values
  localparam logic [2:0] RATIO_RST = 3'h3;
  localparam logic [2:0] POSTSCALE_RST = 3'h1;
  localparam logic [5:0] TRIM_RST = 6'h00;
  // unlock keys
  localparam logic [7:0] KEY_HI_A = 8'h78;
  localparam logic [7:0] KEY_HI_B = 8'h9a;
  localparam logic [7:0] KEY_LO_A = 8'h46;
  localparam logic [7:0] KEY_LO_B = 8'h57;
  // new-clock cycles waited before the switch
  localparam int SETTLE_CYCLES = 10;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [2:0] {
    OSCSD_SRC_FAST_RC = 3'h0,
    OSCSD_SRC_FAST_RC_MULT = 3'h1,
    OSCSD_SRC_PRIMARY = 3'h2,
    OSCSD_SRC_PRIMARY_PLL = 3'h3,
    OSCSD_SRC_SECONDARY = 3'h4,
    OSCSD_SRC_LOW_POWER_RC = 3'h5,
    OSCSD_SRC_SLOW_RC_DIV = 3'h6,
    OSCSD_SRC_FAST_RC_DIV = 3'h7
  } oscsd_src_t;

  typedef enum logic [1:0] {
    OSCSD_SW_IDLE = 2'b00,
    OSCSD_SW_START = 2'b01,
    OSCSD_SW_SETTLE = 2'b11
  } oscsd_sw_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } oscsd_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } oscsd_avs_rsp_t;

  typedef struct packed {
    logic [2:0] src_sel;
    logic secondary_osc_en;
    logic secondary_osc_high_power;
    logic ratio_en;
    logic [2:0] ratio;
    logic [2:0] postscale;
    logic [5:0] trim;
  } oscsd_ctrl_t;
endpackage : oscsd_pkg

// File: rtl/oscsd_top.sv
// oscillator select, clock divider and fast rc trim control with an avalon-mm slave
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// Contract
// - current source field read-only, hardware updated
// - next source writable, reset from configuration
// - lock bit freezes selections when monitor enabled
// - monitor disabled: lock ignored, switching allowed
// - pll lock status reflects locked or timer
// - pll lock zero during switch, non-pll mode
// - hardware sets clock fail; software clears only
// - drive bit forces high-power secondary circuit
// - digital-input secondary: drive bit has no effect
// - enable bit turns secondary oscillator on
// - switch request starts switch, hardware clears
// - recover bit: interrupt restores 1:1 ratio
// - interrupt clears ratio enable when recover set
// - postscale divides 8 MHz, default divide 2
// - postscale divides 500 kHz same codes
// - six-bit signed fast rc trim field
// - same source: abort; else clear lock, fail (code clears only fail; lock stays set until reset)
// - wait ten new clocks then copy selection
// - switching disabled: request held zero
module oscsd_top (
  input wire logic clk_i, // 50 MHz system clock
  input wire logic rstn_i, // async reset, active low
  input wire oscsd_pkg::oscsd_avs_req_t avs_req_i, // avalon-mm request
  output oscsd_pkg::oscsd_avs_rsp_t avs_rsp_o, // avalon-mm answer
  input wire logic [2:0] initial_clock_cfg_i, // fuse: power-on source
  input wire logic switch_monitor_cfg_i, // fuse: 0 enables switching
  input wire logic fail_safe_monitor_en_i, // fail-safe monitor enabled
  input wire logic secondary_source_cfg_i, // fuse: 0 digital input, 1 crystal
  input wire logic pll_locked_i, // pin: pll locked or timer satisfied
  input wire logic source_ready_i, // pin: new source running and settled
  input wire logic new_clock_tick_i, // pin: toggles each new-source cycle
  input wire logic clock_fail_i, // pin: monitor detected a failure
  input wire logic irq_i, // interrupt taken, same clock domain
  output oscsd_pkg::oscsd_ctrl_t ctrl_o // selects to the clock tree
);
  // pin inputs through two flops
  logic [3:0] sync1, sync2;
  logic pll_locked_s, ready_s, tick_s, fail_s, tick_d;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      tick_d <= 1'b0;
    end
    else
    begin
      sync1 <= {pll_locked_i, source_ready_i, new_clock_tick_i, clock_fail_i};
      sync2 <= sync1;
      tick_d <= tick_s;
    end
  end
  assign {pll_locked_s, ready_s, tick_s, fail_s} = sync2;
  wire new_clk_edge = tick_s ^ tick_d;
  function automatic logic uses_pll(input logic [2:0] s);
    uses_pll = (s == oscsd_pkg::OSCSD_SRC_PRIMARY_PLL) || (s == oscsd_pkg::OSCSD_SRC_FAST_RC_MULT);
  endfunction : uses_pll

  // registers
  logic [2:0] cur_sel, next_sel, ratio, postscale;
  logic sel_lock, clk_fail, secondary_osc_drv, secondary_osc_en, sw_req, recover_irq, ratio_en, cfg_loaded;
  logic [5:0] trim;
  logic [1:0] hi_key, lo_key;
  oscsd_pkg::oscsd_sw_state_t sw_state;
  logic [3:0] settle_cnt;

  wire switching_on = !switch_monitor_cfg_i;
  wire lock_active = switching_on && fail_safe_monitor_en_i && sel_lock;
  wire is_osc = avs_req_i.address == oscsd_pkg::OFF_OSC_CONTROL;
  wire is_div = avs_req_i.address == oscsd_pkg::OFF_CLOCK_DIVIDER;
  wire is_tune = avs_req_i.address == oscsd_pkg::OFF_FAST_RC_TUNE;
  wire wr = avs_req_i.write;
  wire [31:0] wd = avs_req_i.writedata;
  wire [3:0] be = avs_req_i.byteenable;
  wire wr_hi = wr && is_osc && be[1];
  wire wr_lo = wr && is_osc && be[0];
  // a new-clock cycle only counts once the source (and pll, if used) is ready
  wire settle_ok = ready_s && (!uses_pll(next_sel) || pll_locked_s) && new_clk_edge;
  wire switch_done = (sw_state == oscsd_pkg::OSCSD_SW_SETTLE) && settle_ok
                     && (settle_cnt == 4'(oscsd_pkg::SETTLE_CYCLES - 1));
  wire redundant = (sw_state == oscsd_pkg::OSCSD_SW_START) && (next_sel == cur_sel);
  wire valid_start = (sw_state == oscsd_pkg::OSCSD_SW_START) && (next_sel != cur_sel);

  // key sequences arm one following byte write
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hi_key <= 2'h0;
      lo_key <= 2'h0;
    end
    else
    begin
      if (wr_hi)
        hi_key <= (hi_key == 2'h0 && wd[15:8] == oscsd_pkg::KEY_HI_A) ? 2'h1 :
                  (hi_key == 2'h1 && wd[15:8] == oscsd_pkg::KEY_HI_B) ? 2'h2 : 2'h0;
      if (wr_lo)
        lo_key <= (lo_key == 2'h0 && wd[7:0] == oscsd_pkg::KEY_LO_A) ? 2'h1 :
                  (lo_key == 2'h1 && wd[7:0] == oscsd_pkg::KEY_LO_B) ? 2'h2 : 2'h0;
    end
  end
  wire hi_store = wr_hi && (hi_key == 2'h2);
  wire lo_store = wr_lo && (lo_key == 2'h2);
  // selection fields, loaded from configuration after reset release
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_loaded <= 1'b0;
      cur_sel <= 3'h0;
      next_sel <= 3'h0;
    end
    else if (!cfg_loaded)
    begin
      cfg_loaded <= 1'b1;
      cur_sel <= initial_clock_cfg_i;
      next_sel <= initial_clock_cfg_i;
    end
    else
    begin
      if (!switching_on)
        cur_sel <= initial_clock_cfg_i;
      else if (switch_done)
        cur_sel <= next_sel;
      if (hi_store && !lock_active && sw_state == oscsd_pkg::OSCSD_SW_IDLE)
        next_sel <= wd[oscsd_pkg::NEXT_SEL_LSB +: 3];
    end
  end

  // switch sequencer
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sw_state <= oscsd_pkg::OSCSD_SW_IDLE;
      sw_req <= 1'b0;
      settle_cnt <= 4'h0;
    end
    else if (!switching_on)
    begin
      sw_state <= oscsd_pkg::OSCSD_SW_IDLE;
      sw_req <= 1'b0;
    end
    else
    begin
      case (sw_state)
        oscsd_pkg::OSCSD_SW_IDLE:
        begin
          if (lo_store && wd[oscsd_pkg::SWITCH_REQ_BIT] && !lock_active && cfg_loaded)
          begin
            sw_req <= 1'b1;
            sw_state <= oscsd_pkg::OSCSD_SW_START;
          end
        end
        oscsd_pkg::OSCSD_SW_START:
        begin
          settle_cnt <= 4'h0;
          if (redundant)
          begin
            sw_req <= 1'b0;
            sw_state <= oscsd_pkg::OSCSD_SW_IDLE;
          end
          else
            sw_state <= oscsd_pkg::OSCSD_SW_SETTLE;
        end
        oscsd_pkg::OSCSD_SW_SETTLE:
        begin
          if (settle_ok)
          begin
            settle_cnt <= settle_cnt + 4'h1;
            if (switch_done)
            begin
              sw_req <= 1'b0;
              sw_state <= oscsd_pkg::OSCSD_SW_IDLE;
            end
          end
        end
        default:
          sw_state <= oscsd_pkg::OSCSD_SW_IDLE;
      endcase
    end
  end

  // lock, fail and secondary oscillator bits
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sel_lock <= 1'b0;
      clk_fail <= 1'b0;
      secondary_osc_drv <= 1'b0;
      secondary_osc_en <= 1'b0;
    end
    else
    begin
      if (lo_store && wd[oscsd_pkg::SEL_LOCK_BIT])
        sel_lock <= 1'b1;
      if (fail_s)
        clk_fail <= 1'b1;
      else if (valid_start)
        clk_fail <= 1'b0;
      else if (lo_store && !wd[oscsd_pkg::CLK_FAIL_BIT])
        clk_fail <= 1'b0;
      if (lo_store)
      begin
        secondary_osc_drv <= wd[oscsd_pkg::SECONDARY_OSC_DRV_BIT];
        secondary_osc_en <= wd[oscsd_pkg::SECONDARY_OSC_EN_BIT];
      end
    end
  end

  // divider and trim
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      recover_irq <= 1'b0;
      ratio <= oscsd_pkg::RATIO_RST;
      ratio_en <= 1'b0;
      postscale <= oscsd_pkg::POSTSCALE_RST;
      trim <= oscsd_pkg::TRIM_RST;
    end
    else
    begin
      if (wr && is_div && be[1])
      begin
        recover_irq <= wd[oscsd_pkg::RECOVER_IRQ_BIT];
        ratio <= wd[oscsd_pkg::RATIO_LSB +: 3];
        postscale <= wd[oscsd_pkg::POSTSCALE_LSB +: 3];
      end
      if (irq_i && recover_irq)
        ratio_en <= 1'b0;
      else if (wr && is_div && be[1])
        ratio_en <= wd[oscsd_pkg::RATIO_EN_BIT];
      if (wr && is_tune && be[0])
        trim <= wd[oscsd_pkg::TRIM_LSB +: 6];
    end
  end

  wire pll_status = pll_locked_s && uses_pll(cur_sel) && sw_state == oscsd_pkg::OSCSD_SW_IDLE;
  // read path: one wait cycle, readdata registered
  logic rd_done;
  logic [31:0] rdata;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_done <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      rd_done <= avs_req_i.read && !rd_done;
      if (!avs_req_i.read)
        rdata <= oscsd_pkg::RD_UNMAPPED;
      else if (is_osc)
        rdata <= {16'h0000, 1'b0, cur_sel, 1'b0, next_sel, sel_lock, 1'b0, pll_status, 1'b0,
                  clk_fail, secondary_osc_drv, secondary_osc_en, sw_req};
      else if (is_div)
        rdata <= {16'h0000, recover_irq, ratio, ratio_en, postscale, 8'h00};
      else if (is_tune)
        rdata <= {26'h0000000, trim};
      else if (avs_req_i.address == oscsd_pkg::OFF_STATUS)
        rdata <= {30'h00000000, sw_state};
      else
        rdata <= oscsd_pkg::RD_UNMAPPED;
    end
  end
  assign avs_rsp_o.readdata = rdata;
  assign avs_rsp_o.waitrequest = avs_req_i.read && !rd_done;

  // outputs to the clock tree
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_o <= '0;
    else
    begin
      ctrl_o.src_sel <= cur_sel;
      ctrl_o.secondary_osc_en <= secondary_osc_en;
      ctrl_o.secondary_osc_high_power <= secondary_source_cfg_i && secondary_osc_drv;
      ctrl_o.ratio_en <= ratio_en;
      ctrl_o.ratio <= ratio;
      ctrl_o.postscale <= postscale;
      ctrl_o.trim <= trim;
    end
  end

  // checks
  property p_sel_ro;
    @(posedge clk_i) disable iff (!rstn_i)
    cfg_loaded && switching_on && !switch_done |=> cur_sel == $past(cur_sel);
  endproperty
  a_sel_ro: assert property (p_sel_ro) else $error("current select changed without switch");
  property p_lock;
    @(posedge clk_i) disable iff (!rstn_i)
    lock_active && sw_state == oscsd_pkg::OSCSD_SW_IDLE |=> !sw_req;
  endproperty
  a_lock: assert property (p_lock) else $error("switch started while locked");
  property p_pll0;
    @(posedge clk_i) disable iff (!rstn_i)
    (sw_state != oscsd_pkg::OSCSD_SW_IDLE) || !uses_pll(cur_sel) |-> !pll_status;
  endproperty
  a_pll0: assert property (p_pll0) else $error("pll status set during switch or non-pll mode");
  property p_fail;
    @(posedge clk_i) disable iff (!rstn_i)
    fail_s |=> clk_fail;
  endproperty
  a_fail: assert property (p_fail) else $error("clock fail not set");
  property p_redundant;
    @(posedge clk_i) disable iff (!rstn_i)
    redundant |=> !sw_req ##1 sw_state == oscsd_pkg::OSCSD_SW_IDLE;
  endproperty
  a_redundant: assert property (p_redundant) else $error("redundant switch not aborted");
  property p_done;
    @(posedge clk_i) disable iff (!rstn_i)
    switch_done && switching_on |=> !sw_req && cur_sel == $past(next_sel);
  endproperty
  a_done: assert property (p_done) else $error("switch completion wrong");
  property p_roi;
    @(posedge clk_i) disable iff (!rstn_i)
    irq_i && recover_irq |=> !ratio_en;
  endproperty
  a_roi: assert property (p_roi) else $error("ratio enable survived interrupt");
  property p_nosw;
    @(posedge clk_i) disable iff (!rstn_i)
    !switching_on |=> !sw_req;
  endproperty
  a_nosw: assert property (p_nosw) else $error("request set with switching disabled");
  c_switch: cover property (@(posedge clk_i) switch_done);
  c_redundant: cover property (@(posedge clk_i) redundant);
  c_roi: cover property (@(posedge clk_i) irq_i && recover_irq && ratio_en);
endmodule : oscsd_top

// File: verif/test_oscillator_select_and_divider.sv
// self-checking bench for the oscillator select, divider and trim registers
`timescale 1ns/1ps
module test_oscillator_select_and_divider;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  oscsd_pkg::oscsd_avs_req_t req = '0;
  oscsd_pkg::oscsd_avs_rsp_t rsp;
  oscsd_pkg::oscsd_ctrl_t ctrl;
  logic [2:0] init_cfg = 3'h7;
  logic sw_dis = 1'b0;
  logic fsm_en = 1'b0;
  logic sec_cfg = 1'b0;
  logic pll_lk = 1'b0;
  logic src_rdy = 1'b0;
  logic tick = 1'b0;
  logic cfail = 1'b0;
  logic irq = 1'b0;
  logic [15:0] rdat;
  int n;
  int miscompares = 0;
  int comparisons = 0;

  always #10 clk_i = ~clk_i;

  oscsd_top DUT (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .avs_req_i(req),
    .avs_rsp_o(rsp),
    .initial_clock_cfg_i(init_cfg),
    .switch_monitor_cfg_i(sw_dis),
    .fail_safe_monitor_en_i(fsm_en),
    .secondary_source_cfg_i(sec_cfg),
    .pll_locked_i(pll_lk),
    .source_ready_i(src_rdy),
    .new_clock_tick_i(tick),
    .clock_fail_i(cfail),
    .irq_i(irq),
    .ctrl_o(ctrl)
  );

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is seen low
  task automatic xfer(input logic [3:0] a, input logic w, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk_i);
    req <= '{address: a, read: ~w, write: w, byteenable: {2'b00, be}, writedata: {16'h0000, d}};
    do
      @(posedge clk_i);
    while (rsp.waitrequest !== 1'b0);
    rdat = rsp.readdata[15:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [3:0] a);
    xfer(a, 1'b0, 16'h0000, 2'b11);
  endtask : rd

  task automatic whi(input logic [7:0] v);
    xfer(4'h0, 1'b1, {oscsd_pkg::KEY_HI_A, 8'h00}, 2'b10);
    xfer(4'h0, 1'b1, {oscsd_pkg::KEY_HI_B, 8'h00}, 2'b10);
    xfer(4'h0, 1'b1, {v, 8'h00}, 2'b10);
  endtask : whi

  task automatic wlo(input logic [7:0] v);
    xfer(4'h0, 1'b1, {8'h00, oscsd_pkg::KEY_LO_A}, 2'b01);
    xfer(4'h0, 1'b1, {8'h00, oscsd_pkg::KEY_LO_B}, 2'b01);
    xfer(4'h0, 1'b1, {8'h00, v}, 2'b01);
  endtask : wlo

  // toggles the new-source clock until the request bit reads clear
  task automatic wait_sw;
    n = 0;
    do
    begin
      @(posedge clk_i);
      tick <= ~tick;
      n++;
      rd(4'h0);
    end
    while (rdat[0] !== 1'b0 && n < 30);
    chk("settle low", 16'h0001, 16'(n >= 10));
    chk("settle high", 16'h0001, 16'(n <= 12));
  endtask : wait_sw

  task automatic t_reset;
    rd(4'h0);
    chk("osc reset", 16'h7700, rdat);
    rd(4'h4);
    chk("div reset", 16'h3100, rdat);
    rd(4'h8);
    chk("tune reset", 16'h0000, rdat);
    rd(4'h6);
    chk("unmapped", 16'h0000, rdat);
    chk("src reset", 16'h0007, 16'(ctrl.src_sel));
    $display("test reset done");
  endtask : t_reset

  task automatic t_switch;
    xfer(4'h0, 1'b1, 16'h0200, 2'b10);
    rd(4'h0);
    chk("no key", 16'h7700, rdat);
    @(posedge clk_i);
    src_rdy <= 1'b1;
    pll_lk <= 1'b1;
    whi(8'h02);
    wlo(8'h07);
    rd(4'hc);
    chk("sw state", 16'h0003, rdat);
    rd(4'h0);
    chk("switching", 16'h7207, rdat);
    wait_sw();
    chk("switched", 16'h2206, rdat);
    chk("src out", 16'h0002, 16'(ctrl.src_sel));
    chk("secondary_osc en", 16'h0001, 16'(ctrl.secondary_osc_en));
    chk("digital drv", 16'h0000, 16'(ctrl.secondary_osc_high_power));
    $display("test switch done");
  endtask : t_switch

  task automatic t_pll;
    @(posedge clk_i);
    cfail <= 1'b1;
    repeat (4) @(posedge clk_i);
    cfail <= 1'b0;
    rd(4'h0);
    chk("fail set", 16'h220e, rdat);
    whi(8'h03);
    wlo(8'h07);
    rd(4'h0);
    chk("valid start", 16'h2307, rdat);
    wait_sw();
    chk("pll locked", 16'h3326, rdat);
    wlo(8'h0e);
    rd(4'h0);
    chk("sw no set", 16'h3326, rdat);
    whi(8'h03);
    wlo(8'h07);
    rd(4'h0);
    rd(4'h0);
    chk("redundant", 16'h3326, rdat);
    $display("test pll done");
  endtask : t_pll

  task automatic t_lock;
    @(posedge clk_i);
    sec_cfg <= 1'b1;
    fsm_en <= 1'b1;
    wlo(8'h86);
    rd(4'h0);
    chk("lock set", 16'h33a6, rdat);
    chk("crystal drv", 16'h0001, 16'(ctrl.secondary_osc_high_power));
    whi(8'h00);
    wlo(8'h87);
    rd(4'h0);
    rd(4'h0);
    chk("locked", 16'h33a6, rdat);
    @(posedge clk_i);
    fsm_en <= 1'b0;
    whi(8'h00);
    wlo(8'h87);
    wait_sw();
    chk("unmonitored", 16'h0086, rdat);
    chk("src fast rc", 16'h0000, 16'(ctrl.src_sel));
    $display("test lock done");
  endtask : t_lock

  task automatic t_div;
    xfer(4'h4, 1'b1, 16'hdfff, 2'b11);
    rd(4'h4);
    chk("div wr", 16'hdf00, rdat);
    chk("ratio out", 16'h0005, 16'(ctrl.ratio));
    chk("post out", 16'h0007, 16'(ctrl.postscale));
    @(posedge clk_i);
    irq <= 1'b1;
    @(posedge clk_i);
    irq <= 1'b0;
    rd(4'h4);
    chk("irq recover", 16'hd700, rdat);
    chk("ratio en out", 16'h0000, 16'(ctrl.ratio_en));
    xfer(4'h4, 1'b1, 16'h5f00, 2'b11);
    @(posedge clk_i);
    irq <= 1'b1;
    @(posedge clk_i);
    irq <= 1'b0;
    rd(4'h4);
    chk("irq kept", 16'h5f00, rdat);
    xfer(4'h8, 1'b1, 16'hffe0, 2'b11);
    rd(4'h8);
    chk("trim neg", 16'h0020, rdat);
    xfer(4'h8, 1'b1, 16'h001f, 2'b11);
    rd(4'h8);
    chk("trim pos", 16'h001f, 16'(ctrl.trim));
    $display("test divider done");
  endtask : t_div

  task automatic t_nosw;
    @(posedge clk_i);
    sw_dis <= 1'b1;
    init_cfg <= 3'h5;
    whi(8'h01);
    wlo(8'h87);
    rd(4'h0);
    chk("req held", 16'h0000, 16'(rdat[0]));
    chk("cur fuse", 16'h0005, 16'(rdat[14:12]));
    $display("test no switch done");
  endtask : t_nosw

  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_switch();
    t_pll();
    t_lock();
    t_div();
    t_nosw();
    close_out();
  end
endmodule : test_oscillator_select_and_divider
